// *** uaxr_defines.svh ***
// register offsets, bit positions, reset values and sample counts
// assumes: included by bare name from uaxr files, no other state
//
// Functional notes
// - receive-complete flag means buffer holds data
// - receiver disable empties buffer, flag reads zero
// - receive irq is level while flag and enable
// - data read frees the buffer head entry
// - error flags travel in buffer with frame
// - status writes never change error flags
// - error flags never raise an interrupt
// - framing flag reflects head frame stop bit
// - only first stop bit is checked
// - two-deep buffer; overrun on full plus waiting frame plus start
// - successful buffer transfer clears overrun
// - parity flag zero for frames received with checking disabled
// - parity checked over data, odd or even
// - parity flag needs checking enabled that frame
// - disable is immediate, frame and data dropped
// - sixteen samples per bit, eight double speed
// - start vote on samples 8-10 or 4-6
// - recovery steps sixteen or eight states per bit
// - each bit is majority of three samples
// - low stop bit sets framing error
// - next start accepted right after stop vote
// - vote centre sample 9, or 5 double speed
// - unused upper data bits read zero
`ifndef UAXR_DEFINES_SVH
`define UAXR_DEFINES_SVH

// -----------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------
`define UAXR_SERIAL_STATUS_OFF   8'h00
`define UAXR_SERIAL_CONTROL_OFF  8'h04
`define UAXR_FRAME_FORMAT_OFF    8'h08
`define UAXR_SERIAL_DATA_OFF     8'h0c

// -----------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------
`define UAXR_ST_RXC      7
`define UAXR_ST_FE       4
`define UAXR_ST_DOR      3
`define UAXR_ST_UPE      2
`define UAXR_CTL_IRQEN   7
`define UAXR_CTL_RXEN    4
`define UAXR_CTL_DBL     1
`define UAXR_FMT_PEN     5
`define UAXR_FMT_PODD    4
`define UAXR_FMT_TWOSTOP 3
`define UAXR_FMT_SIZE    1
`define UAXR_CTL_RESET   8'h00
`define UAXR_FMT_RESET   8'h06

// -----------------------------------------------------------
// samples per bit and vote centre
// -----------------------------------------------------------
`define UAXR_SPB_NORM    5'h10
`define UAXR_SPB_DBL     5'h08
`define UAXR_MID_NORM    5'h09
`define UAXR_MID_DBL     5'h05

`endif

// *** uaxr_pkg.sv ***
// types shared by the receiver files
// assumes: nothing outside itself
package uaxr_pkg;

	// frame recovery states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_DATA  = 5'h04,
		ST_PAR   = 5'h08,
		ST_STOP  = 5'h10
	} uaxr_state_t;

	// one receive buffer entry: flags stored with frame
	typedef struct packed {
		logic       overrun_flag;
		logic       parity_error_flag;
		logic       framing_error_flag;
		logic [7:0] data;
	} uaxr_entry_t;

	// software control bits
	typedef struct packed {
		logic rx_complete_irq_enable;
		logic receiver_enable_bit;
		logic double_speed_select;
	} uaxr_ctl_t;

	// frame format bits
	typedef struct packed {
		logic       parity_enable_bit;
		logic       parity_odd_select;
		logic       two_stop_select;
		logic [1:0] char_size;
	} uaxr_fmt_t;

endpackage

// *** uaxr_rxbuf.sv ***
// receive buffer fifo: holds received frames with their flags
// assumes: one clock; push ignored when full, pop when empty
`timescale 1ns/1ps
module uaxr_rxbuf #(
	parameter int W     = 11,
	parameter int DEPTH = 2,
	localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
	localparam int CW   = $clog2(DEPTH + 1)
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ce,
	input  wire logic          push,
	input  wire logic          pop,
	input  wire logic          flush,
	input  wire logic [W-1:0]  din,
	output logic      [W-1:0]  dout,
	output logic      [CW-1:0] count,
	output logic               full,
	output logic               empty
);
	logic [W-1:0]  mem [DEPTH];  // entry storage
	logic [AW-1:0] wp_q;         // write pointer
	logic [AW-1:0] rp_q;         // read pointer
	logic [CW-1:0] cnt_q;        // entries held
	logic          do_push;
	logic          do_pop;

	// pointer step with wrap for any depth
	function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign full    = (cnt_q == CW'(DEPTH));
	assign empty   = (cnt_q == '0);
	assign count   = cnt_q;
	assign dout    = mem[rp_q];

	// storage write
	always_ff @(posedge pclk) begin
		if (ce && do_push && !flush) begin
			mem[wp_q] <= din;
		end
	end

	// pointers and fill count; flush empties at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			if (flush) begin
				wp_q  <= '0;
				rp_q  <= '0;
				cnt_q <= '0;
			end else begin
				if (do_push) wp_q <= nxt(wp_q);
				if (do_pop) rp_q <= nxt(rp_q);
				cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
			end
		end
	end
endmodule

// *** uaxr_sampler.sv ***
// sample counter and three-sample majority window of one bit
// assumes: tick is one pclk cycle at 16x or 8x the baud rate
`timescale 1ns/1ps
`include "uaxr_defines.svh"
module uaxr_sampler (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       tick,
	input  wire logic       restart,
	input  wire logic       dbl,
	input  wire logic       line,
	output logic      [4:0] cnt,
	output logic            vote_stb,
	output logic            vote_val
);
	logic [4:0] cnt_q;  // sample number within the bit
	logic [4:0] cnt_n;  // sample number after this tick
	logic [4:0] spb;    // samples per bit
	logic [4:0] mid;    // centre sample
	logic [1:0] win_q;  // first two voted samples

	// two or three equal samples decide the bit
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	assign spb = dbl ? `UAXR_SPB_DBL : `UAXR_SPB_NORM;
	assign mid = dbl ? `UAXR_MID_DBL : `UAXR_MID_NORM;

	// first low sample is sample 1, then 1..spb per bit
	always_comb begin
		if (restart) cnt_n = 5'h01;
		else if (cnt_q >= spb) cnt_n = 5'h01;
		else cnt_n = cnt_q + 5'h01;
	end

	// counter advances only on sample ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cnt_q <= 5'h00;
		else if (ce && tick) cnt_q <= cnt_n;
	end

	// keep samples mid-1 and mid for the vote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q <= 2'h3;
		end else if (ce && tick && cnt_n >= mid - 5'h01 &&
			cnt_n <= mid) begin
			win_q <= {win_q[0], line};
		end
	end

	assign cnt      = cnt_q;
	assign vote_stb = ce & tick & (cnt_n == mid + 5'h01);
	assign vote_val = maj3({win_q, line});
endmodule

// *** uaxr_rx.sv ***
// serial receiver with apb registers and two-deep buffer
// assumes: apb master, sample_tick from a baud generator,
// serial_rx_pin already synchronous to pclk
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "uaxr_defines.svh"
module uaxr_rx #(
	parameter int DEPTH = 2
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sample_tick,
	input  wire logic        serial_rx_pin,
	output logic             rx_irq,
	output logic             rx_pin_owned
);
	localparam int CW = $clog2(DEPTH + 1);
	// reset words held as constants so their bits can be selected
	localparam logic [7:0] CTL_RST = `UAXR_CTL_RESET;
	localparam logic [7:0] FMT_RST = `UAXR_FMT_RESET;

	// -----------------------------------------------------------
	// registers and internal signals
	// -----------------------------------------------------------
	uaxr_pkg::uaxr_ctl_t   ctl_q;        // serial control reg
	uaxr_pkg::uaxr_fmt_t   fmt_q;        // frame format reg
	uaxr_pkg::uaxr_state_t st_q;         // recovery state
	uaxr_pkg::uaxr_entry_t hold_q;       // frame in shift reg
	uaxr_pkg::uaxr_entry_t head;         // buffer head entry
	logic                  hold_v_q;     // shift reg holds frame
	logic                  dor_pend_q;   // overrun for next push
	logic [7:0]            data_sr_q;    // received data bits
	logic [2:0]            bit_idx_q;    // data bit index
	logic                  pbit_q;       // received parity bit
	logic                  pen_f_q;      // parity check this frame
	logic                  odd_f_q;      // parity sense this frame
	logic                  prev_q;       // line at previous tick
	logic [31:0]           prdata_q;     // read data
	logic                  pready_q;     // access phase ready
	logic                  pslverr_q;    // unmapped address
	logic                  irq_q;        // receive irq level
	logic                  own_q;        // receiver owns pin
	logic                  rx_en;
	logic                  start_edge;
	logic                  vote_stb;
	logic                  vote_val;
	logic                  complete;
	logic                  push;
	logic                  acc;
	logic                  wr;
	logic                  rd_pop;
	logic                  full;
	logic                  empty;
	logic                  dor_set;
	logic                  upe_now;
	logic [2:0]            last_idx;
	logic [CW-1:0]         buf_cnt;
	logic [10:0]           head_raw;
	logic [31:0]           rd_val;

	// true when offset names a register
	function automatic logic is_map(input logic [7:0] a);
		return a == `UAXR_SERIAL_STATUS_OFF ||
			a == `UAXR_SERIAL_CONTROL_OFF ||
			a == `UAXR_FRAME_FORMAT_OFF ||
			a == `UAXR_SERIAL_DATA_OFF;
	endfunction

	assign rx_en    = ctl_q.receiver_enable_bit;
	assign last_idx = 3'h4 + {1'b0, fmt_q.char_size};
	assign head     = uaxr_pkg::uaxr_entry_t'(head_raw);

	// -----------------------------------------------------------
	// sample counter and majority vote
	// -----------------------------------------------------------
	uaxr_sampler u_samp (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.tick     (sample_tick),
		.restart  (start_edge),
		.dbl      (ctl_q.double_speed_select),
		.line     (serial_rx_pin),
		.cnt      (),
		.vote_stb (vote_stb),
		.vote_val (vote_val)
	);

	// -----------------------------------------------------------
	// receive buffer
	// -----------------------------------------------------------
	uaxr_rxbuf #(
		.W     ($bits(uaxr_pkg::uaxr_entry_t)),
		.DEPTH (DEPTH)
	) u_buf (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.push    (push),
		.pop     (rd_pop),
		.flush   (!rx_en),
		.din     ({dor_pend_q | dor_set, hold_q[9:0]}),
		.dout    (head_raw),
		.count   (buf_cnt),
		.full    (full),
		.empty   (empty)
	);

	// -----------------------------------------------------------
	// start detection and frame recovery
	// -----------------------------------------------------------
	// idle high to low at a sample tick opens a start bit
	assign start_edge = (st_q == uaxr_pkg::ST_IDLE) & rx_en &
		sample_tick & prev_q & ~serial_rx_pin;

	// stop bit voted: frame sits whole in the shift register
	assign complete = (st_q == uaxr_pkg::ST_STOP) & vote_stb;

	// parity of data plus parity bit against chosen sense
	assign upe_now = pen_f_q &
		(^data_sr_q ^ pbit_q ^ odd_f_q);

	// overrun: valid start while buffer full and frame waiting
	assign dor_set = (st_q == uaxr_pkg::ST_START) & vote_stb &
		~vote_val & full & hold_v_q;

	// move a waiting frame into the buffer when room exists
	assign push = hold_v_q & ~full & rx_en;

	// line history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prev_q <= 1'b1;
		else if (ce && sample_tick) prev_q <= serial_rx_pin;
	end

	// recovery state machine, one state per frame field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= uaxr_pkg::ST_IDLE;
		end else if (ce) begin
			if (!rx_en) begin
				st_q <= uaxr_pkg::ST_IDLE;
			end else begin
				case (st_q)
					uaxr_pkg::ST_IDLE: begin
						if (start_edge) st_q <= uaxr_pkg::ST_START;
					end
					uaxr_pkg::ST_START: begin
						// majority high: noise, search again
						if (vote_stb) begin
							st_q <= vote_val ? uaxr_pkg::ST_IDLE
								: uaxr_pkg::ST_DATA;
						end
					end
					uaxr_pkg::ST_DATA: begin
						if (vote_stb && bit_idx_q == last_idx) begin
							st_q <= pen_f_q ? uaxr_pkg::ST_PAR
								: uaxr_pkg::ST_STOP;
						end
					end
					uaxr_pkg::ST_PAR: begin
						if (vote_stb) st_q <= uaxr_pkg::ST_STOP;
					end
					uaxr_pkg::ST_STOP: begin
						// free for next edge after the vote
						if (vote_stb) st_q <= uaxr_pkg::ST_IDLE;
					end
					default: st_q <= uaxr_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// data shift register and per-frame parity settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_sr_q <= 8'h00;
			bit_idx_q <= 3'h0;
			pbit_q    <= 1'b0;
			pen_f_q   <= 1'b0;
			odd_f_q   <= 1'b0;
		end else if (ce && vote_stb) begin
			if (st_q == uaxr_pkg::ST_START) begin
				// clear so short frames leave upper bits zero
				data_sr_q <= 8'h00;
				bit_idx_q <= 3'h0;
				pen_f_q   <= fmt_q.parity_enable_bit;
				odd_f_q   <= fmt_q.parity_odd_select;
			end else if (st_q == uaxr_pkg::ST_DATA) begin
				data_sr_q[bit_idx_q] <= vote_val;
				bit_idx_q <= bit_idx_q + 3'h1;
			end else if (st_q == uaxr_pkg::ST_PAR) begin
				pbit_q <= vote_val;
			end
		end
	end

	// finished frame waits here until the buffer has room
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q   <= '0;
			hold_v_q <= 1'b0;
		end else if (ce) begin
			if (!rx_en) begin
				hold_v_q <= 1'b0;
			end else if (complete) begin
				// only first stop bit decides framing
				hold_q.framing_error_flag <= ~vote_val;
				hold_q.parity_error_flag  <= upe_now;
				hold_q.data               <= data_sr_q;
				hold_v_q                  <= 1'b1;
			end else if (push) begin
				hold_v_q <= 1'b0;
			end
		end
	end

	// overrun pending, attached to the next pushed frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dor_pend_q <= 1'b0;
		end else if (ce) begin
			if (!rx_en) dor_pend_q <= 1'b0;
			else if (dor_set) dor_pend_q <= 1'b1;  // set wins
			else if (push) dor_pend_q <= 1'b0;
		end
	end

	// -----------------------------------------------------------
	// apb slave
	// -----------------------------------------------------------
	assign acc    = psel & penable & pready_q;
	assign wr     = acc & pwrite & is_map(paddr);
	assign rd_pop = acc & ~pwrite & ~empty &
		(paddr == `UAXR_SERIAL_DATA_OFF);

	// read value chosen during the setup cycle
	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			`UAXR_SERIAL_STATUS_OFF: begin
				rd_val[`UAXR_ST_RXC] = ~empty;
				rd_val[`UAXR_ST_FE]  = ~empty &
					head.framing_error_flag;
				rd_val[`UAXR_ST_DOR] = ~empty & head.overrun_flag;
				rd_val[`UAXR_ST_UPE] = ~empty &
					head.parity_error_flag;
			end
			`UAXR_SERIAL_CONTROL_OFF: begin
				rd_val[`UAXR_CTL_IRQEN] = ctl_q.rx_complete_irq_enable;
				rd_val[`UAXR_CTL_RXEN]  = ctl_q.receiver_enable_bit;
				rd_val[`UAXR_CTL_DBL]   = ctl_q.double_speed_select;
			end
			`UAXR_FRAME_FORMAT_OFF: begin
				rd_val[`UAXR_FMT_PEN]     = fmt_q.parity_enable_bit;
				rd_val[`UAXR_FMT_PODD]    = fmt_q.parity_odd_select;
				rd_val[`UAXR_FMT_TWOSTOP] = fmt_q.two_stop_select;
				rd_val[`UAXR_FMT_SIZE +: 2] = fmt_q.char_size;
			end
			`UAXR_SERIAL_DATA_OFF: begin
				if (!empty) rd_val[7:0] = head.data;
			end
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// one wait-free access: ready in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else if (ce) begin
			pready_q <= psel & ~penable;
			if (psel && !penable) begin
				pslverr_q <= ~is_map(paddr);
				prdata_q  <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end
	end

	// control and format writes; status writes change nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= uaxr_pkg::uaxr_ctl_t'({
				CTL_RST[`UAXR_CTL_IRQEN],
				CTL_RST[`UAXR_CTL_RXEN],
				CTL_RST[`UAXR_CTL_DBL]});
			fmt_q <= uaxr_pkg::uaxr_fmt_t'(
				FMT_RST[`UAXR_FMT_PEN:`UAXR_FMT_SIZE]);
		end else if (ce && wr) begin
			if (paddr == `UAXR_SERIAL_CONTROL_OFF) begin
				ctl_q.rx_complete_irq_enable <= pwdata[`UAXR_CTL_IRQEN];
				ctl_q.receiver_enable_bit    <= pwdata[`UAXR_CTL_RXEN];
				ctl_q.double_speed_select    <= pwdata[`UAXR_CTL_DBL];
			end
			if (paddr == `UAXR_FRAME_FORMAT_OFF) begin
				fmt_q <= uaxr_pkg::uaxr_fmt_t'(
					pwdata[`UAXR_FMT_PEN:`UAXR_FMT_SIZE]);
			end
		end
	end

	// irq from receive-complete only; error flags never feed it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
			own_q <= 1'b0;
		end else if (ce) begin
			irq_q <= ctl_q.rx_complete_irq_enable & ~empty;
			own_q <= rx_en;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign rx_irq       = irq_q;
	assign rx_pin_owned = own_q;

	// -----------------------------------------------------------
	// assertions
	// -----------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_stop_vote;
		ce && st_q == uaxr_pkg::ST_STOP && vote_stb && rx_en;
	endsequence

	sequence s_start_reject;
		ce && rx_en && st_q == uaxr_pkg::ST_START && vote_stb &&
			vote_val;
	endsequence

	status_rxc_a: assert property (ce && psel && !penable && !pwrite &&
		paddr == `UAXR_SERIAL_STATUS_OFF |=>
		prdata_q[`UAXR_ST_RXC] == ($past(buf_cnt) != '0))
		else $error("status read flag disagrees with buffer");
	flush_dis_a: assert property (ce && !rx_en |=>
		buf_cnt == '0)
		else $error("buffer not emptied on disable");
	irq_level_a: assert property (ce |=> rx_irq ==
		$past(ctl_q.rx_complete_irq_enable && buf_cnt != '0))
		else $error("irq level wrong");
	pop_read_a: assert property (ce && rd_pop && !push |=>
		buf_cnt == $past(buf_cnt) - CW'(1))
		else $error("data read did not free entry");
	upe_off_a: assert property (ce && complete && !pen_f_q && rx_en |=>
		!hold_q.parity_error_flag)
		else $error("parity flag set with checking off");
	dor_clear_a: assert property (ce && push && !dor_set && rx_en |=>
		!dor_pend_q)
		else $error("overrun not cleared on transfer");
	fe_stop_a: assert property (ce && complete && rx_en |=>
		hold_q.framing_error_flag == !$past(vote_val))
		else $error("framing flag not from stop vote");
	start_reject_a: assert property (s_start_reject |=>
		st_q == uaxr_pkg::ST_IDLE)
		else $error("noisy start not rejected");
	stop_idle_a: assert property (s_stop_vote |=>
		st_q == uaxr_pkg::ST_IDLE && hold_v_q)
		else $error("not ready for next start after stop");
	disable_now_a: assert property (ce && !rx_en |=>
		st_q == uaxr_pkg::ST_IDLE && !hold_v_q)
		else $error("disable did not drop reception");
endmodule

// *** uaxr_tx_model.sv ***
// remote serial transmitter model on the receive line
// assumes: bits advance on sample_tick edges of pclk
`timescale 1ns/1ps
module uaxr_tx_model (
	input  wire logic pclk,
	input  wire logic sample_tick,
	output logic      line
);
	initial line = 1'b1; // idle level of the pulled-up line

	// hold one level for n sample ticks
	task automatic hold(input logic v, input int n);
		line <= v;
		repeat (n) @(posedge pclk iff sample_tick);
	endtask

	// one frame: start, lsb first data, optional parity, stop
	task automatic send(input logic [7:0] d, input int nb, spb, stn,
		input logic pen, podd, pbad, stv);
		logic p;
		p = ^(d & 8'((1 << nb) - 1)) ^ podd ^ pbad;
		hold(1'b0, spb);
		for (int i = 0; i < nb; i++)
			hold(d[i], spb);
		if (pen)
			hold(p, spb);
		hold(stv, stn); // short stop allowed
		// a low stop is followed by one idle tick; a good stop
		// already leaves the line at its idle level
		if (!stv)
			hold(1'b1, 1);
	endtask
endmodule

// *** tb_top.sv ***
// self-checking bench of the serial receiver
// assumes: apb master here, transmitter model on the line
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, sample_tick;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, rx_irq, rx_pin_owned, line, perr;
	logic [1:0]  tdiv;
	int          n_fail, checks, spb;

	uaxr_rx u_uaxr_rx (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_tick(sample_tick),
		.serial_rx_pin(line), .rx_irq(rx_irq),
		.rx_pin_owned(rx_pin_owned));
	uaxr_tx_model u_uaxr_tx_model (.pclk(pclk),
		.sample_tick(sample_tick), .line(line));

	// ---------------------------------------------
	// clock and sample tick, one tick every 4 cycles
	// ---------------------------------------------
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		tdiv <= tdiv + 2'h1;
		sample_tick <= (tdiv == 2'h3);
	end

	// compare and count
	task automatic chk(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		perr = pslverr;
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		apb(1'b1, a, d, x);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		apb(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	// send a plain 8-bit frame, stop length n ticks
	task automatic tx(input logic [7:0] d, input int n);
		u_uaxr_tx_model.send(d, 8, spb, n, 0, 0, 0, 1);
	endtask
	task automatic settle();
		repeat (8) @(posedge pclk);
	endtask

	// ---------------------------------------------
	// scenarios
	// ---------------------------------------------
	task automatic t_basic();
		rd(8'h08, 32'h06);
		rd(8'h10, 32'h0);
		chk(perr, 1'b1);
		rd(8'h00, 32'h0);
		wr(8'h04, 32'h90);
		tx(8'ha5, 16);
		settle();
		chk(rx_irq, 1'b1);
		chk(rx_pin_owned, 1'b1);
		rd(8'h00, 32'h80);
		rd(8'h0c, 32'ha5);
		rd(8'h00, 32'h0);
		chk(rx_irq, 1'b0);
		$display("done basic");
	endtask

	task automatic t_frame();
		wr(8'h0e, 32'h0);
		chk(perr, 1'b1);
		wr(8'h04, 32'h10);
		wr(8'h08, 32'h0e);
		u_uaxr_tx_model.send(8'h3c, 8, spb, 16, 0, 0, 0, 0);
		settle();
		chk(rx_irq, 1'b0);
		rd(8'h00, 32'h90);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h90);
		rd(8'h0c, 32'h3c);
		wr(8'h08, 32'h06);
		$display("done framing");
	endtask

	task automatic t_parity();
		for (int k = 0; k < 4; k++) begin
			wr(8'h08, 32'h26 | (k[0] << 4));
			u_uaxr_tx_model.send(8'(32'h5a ^ k), 8, spb, 16, 1, k[0],
				k[1], 1);
			wr(8'h08, 32'h06);
			tx(8'h11, 16);
			settle();
			rd(8'h00, k[1] ? 32'h84 : 32'h80);
			rd(8'h0c, 32'h5a ^ k);
			rd(8'h00, 32'h80);
			rd(8'h0c, 32'h11);
		end
		$display("done parity");
	endtask

	task automatic t_misc();
		wr(8'h08, 32'h00);
		u_uaxr_tx_model.send(8'hff, 5, spb, 16, 0, 0, 0, 1);
		settle();
		rd(8'h0c, 32'h1f);
		wr(8'h08, 32'h06);
		u_uaxr_tx_model.hold(1'b0, 3);
		u_uaxr_tx_model.hold(1'b1, 40);
		rd(8'h00, 32'h0);
		tx(8'h21, 10);
		tx(8'h42, 10);
		settle();
		rd(8'h0c, 32'h21);
		rd(8'h0c, 32'h42);
		wr(8'h04, 32'h12);
		spb = 8;
		tx(8'hc3, 6);
		tx(8'h3c, 6);
		settle();
		rd(8'h0c, 32'hc3);
		rd(8'h0c, 32'h3c);
		spb = 16;
		wr(8'h04, 32'h10);
		$display("done format speed noise");
	endtask

	task automatic t_over();
		for (int i = 1; i < 5; i++)
			tx(8'(i), 16);
		settle();
		rd(8'h00, 32'h80);
		rd(8'h0c, 32'h01);
		rd(8'h00, 32'h80);
		rd(8'h0c, 32'h02);
		rd(8'h00, 32'h88);
		rd(8'h0c, 32'h04);
		tx(8'h05, 16);
		settle();
		rd(8'h00, 32'h80);
		rd(8'h0c, 32'h05);
		rd(8'h00, 32'h0);
		$display("done overrun");
	endtask

	task automatic t_dis();
		tx(8'h77, 16);
		settle();
		wr(8'h04, 32'h00);
		rd(8'h00, 32'h0);
		chk(rx_pin_owned, 1'b0);
		wr(8'h04, 32'h10);
		rd(8'h00, 32'h0);
		fork
			tx(8'hff, 16);
			begin
				repeat (200) @(posedge pclk);
				wr(8'h04, 32'h00);
				wr(8'h04, 32'h10);
			end
		join
		settle();
		rd(8'h00, 32'h0);
		$display("done disable");
	endtask

	// verdict and end of run
	task automatic end_sim();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#4000000;
		n_fail++;
		end_sim();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sample_tick = 1'b0;
		tdiv = 2'h0;
		spb = 16;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_basic();
		t_frame();
		t_parity();
		t_misc();
		t_over();
		t_dis();
		end_sim();
	end
endmodule
